/* File: sdt_map.svh */
`ifndef SDT_MAP_SVH
`define SDT_MAP_SVH

// register addresses on the plain register port
`define SDT_ADDR_CLK_SEL   8'h8E
`define SDT_ADDR_IRQ_EN    8'hA8
`define SDT_ADDR_CTL       8'hC8
`define SDT_ADDR_LO_RLD    8'hCA
`define SDT_ADDR_HI_RLD    8'hCB
`define SDT_ADDR_LO_CNT    8'hCC
`define SDT_ADDR_HI_CNT    8'hCD
`define SDT_ADDR_LO_CAPT   8'hD2
`define SDT_ADDR_HI_CAPT   8'hD3
`define SDT_ADDR_EVT_STAT  8'hD4
`define SDT_ADDR_EVT_MASK  8'hD5

// timer control register fields
`define SDT_CTL_HI_FLAG    7
`define SDT_CTL_LO_FLAG    6
`define SDT_CTL_LO_IRQ_EN  5
`define SDT_CTL_CAPT_EN    4
`define SDT_CTL_SPLIT      3
`define SDT_CTL_RUN        2
`define SDT_CTL_EXT_SEL    0

// clock select register fields
`define SDT_CKS_HI_FAST    5
`define SDT_CKS_LO_FAST    4

// irq enable register field
`define SDT_IRQ_EN_TIMER   5

// event status / mask bits
`define SDT_EVT_HI_OVF     0
`define SDT_EVT_LO_OVF     1
`define SDT_EVT_CAPT       2

// reset values
`define SDT_RST_BYTE       8'h00
`define SDT_RST_EVT        3'h0

// tick dividers
`define SDT_SYS_DIV        12
`define SDT_EXT_DIV        8

`endif

/* File: sdt_pkg.sv */
package sdt_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sdt_bus_req_t;

  typedef struct packed {
    logic       sync0;
    logic       sync1;
    logic       sync2;
    logic [3:0] sys_cnt;
    logic [3:0] ext_cnt;
    logic       sys_tick;
    logic       ext_tick;
  } sdt_tick_state_t;

  typedef struct packed {
    logic [7:0] count;
  } sdt_half_state_t;

  typedef struct packed {
    logic       hi_flag;
    logic       lo_flag;
    logic       lo_irq_en;
    logic       capt_en;
    logic       split;
    logic       run;
    logic       ext_sel;
    logic       hi_fast;
    logic       lo_fast;
    logic       tmr_irq_en;
    logic [7:0] lo_rld;
    logic [7:0] hi_rld;
    logic [7:0] lo_capt;
    logic [7:0] hi_capt;
    logic [2:0] evt_stat;
    logic [2:0] evt_mask;
    logic       cmp_prev;
    logic [7:0] rdata;
  } sdt_state_t;

endpackage : sdt_pkg

/* File: sdt_tick_gen.sv */
`timescale 1ns/10ps
`include "sdt_map.svh"

module sdt_tick_gen #(
  parameter int SYS_DIV = `SDT_SYS_DIV,
  parameter int EXT_DIV = `SDT_EXT_DIV
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // raw external clock
  input  wire logic ext_clk_i,
  // count-enable pulses
  output logic      sys_tick_o,
  output logic      ext_tick_o
);
  import sdt_pkg::*;

  if (SYS_DIV < 2 || SYS_DIV > 16 || EXT_DIV < 2 || EXT_DIV > 16) begin : g_chk
    $error("sdt_tick_gen: dividers must lie in 2..16");
  end

  localparam logic [3:0] SYS_LAST = 4'(SYS_DIV - 1);
  localparam logic [3:0] EXT_LAST = 4'(EXT_DIV - 1);

  sdt_tick_state_t st_reg;
  sdt_tick_state_t st_next;
  logic            ext_rise;

  // sync1 only samples sync0; the edge is taken between sync1 and sync2
  assign ext_rise = st_reg.sync1 & ~st_reg.sync2;

  always_comb begin
    st_next          = st_reg;
    st_next.sync0    = ext_clk_i;
    st_next.sync1    = st_reg.sync0;
    st_next.sync2    = st_reg.sync1;
    st_next.sys_tick = (st_reg.sys_cnt == SYS_LAST); // RL5
    st_next.sys_cnt  = st_next.sys_tick ? 4'h0 : st_reg.sys_cnt + 4'h1;
    st_next.ext_tick = 1'b0;
    if (ext_rise) begin
      st_next.ext_tick = (st_reg.ext_cnt == EXT_LAST); // RL18
      st_next.ext_cnt  = st_next.ext_tick ? 4'h0 : st_reg.ext_cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sys_tick_o = st_reg.sys_tick;
  assign ext_tick_o = st_reg.ext_tick;

  sequence s_sys_gap;
    (!sys_tick_o)[*8] ##1 !sys_tick_o ##1 !sys_tick_o ##1 !sys_tick_o;
  endsequence

  a_sys_div_period: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL5
    sys_tick_o && SYS_DIV == 12 |=> s_sys_gap ##1 sys_tick_o)
    else $error("system divided tick not every twelve cycles");

  a_ext_pulse_one: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL18
    ext_tick_o |=> !ext_tick_o)
    else $error("external tick longer than one cycle");

endmodule : sdt_tick_gen

/* File: sdt_half_counter.sv */
`timescale 1ns/10ps
`include "sdt_map.svh"

module sdt_half_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // counting
  input  wire logic       tick_i,
  input  wire logic       run_i,
  input  wire logic [7:0] reload_i,
  // software access
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  // state
  output logic [7:0]      count_o,
  output logic            ovf_o
);
  import sdt_pkg::*;

  if (WIDTH != 8) begin : g_chk
    $error("sdt_half_counter: only 8-bit halves are supported");
  end

  sdt_half_state_t st_reg;
  sdt_half_state_t st_next;
  logic            step;

  assign step  = tick_i & run_i;
  assign ovf_o = step & (st_reg.count == 8'hFF) & ~wr_i; // RL8

  always_comb begin
    st_next = st_reg;
    if (wr_i) begin
      st_next.count = wdata_i;
    end else if (ovf_o) begin
      st_next.count = reload_i; // RL2 RL17
    end else if (step) begin
      st_next.count = st_reg.count + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg.count <= `SDT_RST_BYTE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count_o = st_reg.count;

  a_wrap_reload: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // RL17
    ovf_o |=> count_o == $past(reload_i))
    else $error("overflow did not load the reload value");

endmodule : sdt_half_counter

/* File: sdt_timer.sv */
// Function
// RL1: split select set runs timer as two separate 8-bit counters.
// RL2: in split mode both halves auto-reload from their own reload register.
// RL3: in split mode run control gates only the high counter.
// RL4: in split mode the low counter counts continuously.
// RL5: fast bit picks system clock, else system/12 or external/8.
// RL6: each half has its own fast bit; external select is shared.
// RL7: high overflow flag sets when high counter wraps FF to 00.
// RL8: low overflow flag sets when low counter wraps FF to 00.
// RL9: with timer irq enabled, every high overflow requests an interrupt.
// RL10: with low irq enable too, either overflow requests an interrupt.
// RL11: overflow flags are never cleared by hardware, only by software.
// RL12: handler checks both flags for the source and clears them.
// RL13: capture mode records count on each comparator rising edge.
// RL14: low count register read/write, resets to zero.
// RL15: high count register read/write, resets to zero.
// RL16: high flag at control bit 7, low flag at bit 6.
// RL17: overflow loads reload value in the tick that sets the flag.
// RL18: external clock/8 synchronised and used as one-cycle count enable.
`timescale 1ns/10ps
`include "sdt_map.svh"

module sdt_timer #(
  parameter int SYS_DIV = `SDT_SYS_DIV,
  parameter int EXT_DIV = `SDT_EXT_DIV
) (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 sys_rst_i,
  // register port
  input  wire sdt_pkg::sdt_bus_req_t bus_i,
  output logic [7:0]                rdata_o,
  // external sources
  input  wire logic                 ext_clk_i,
  input  wire logic                 cmp_out_i,
  // interrupt
  output logic                      irq_o
);
  import sdt_pkg::*;

  sdt_state_t  st_reg;
  sdt_state_t  st_next;
  logic        sys_tick;
  logic        ext_tick;
  logic [1:0]  tick;
  logic [1:0]  run;
  logic [1:0]  fast;
  logic [1:0]  cnt_wr;
  logic [1:0]  ovf;
  logic [7:0]  cnt   [2];
  logic [7:0]  rld   [2];
  logic [7:0]  rd_mux;
  logic        wr_ctl;
  logic        cmp_rise;
  logic [2:0]  evt_set;
  logic        tmr_req;

  sdt_tick_gen #(
    .SYS_DIV (SYS_DIV),
    .EXT_DIV (EXT_DIV)
  ) u_ticks (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .ext_clk_i  (ext_clk_i),
    .sys_tick_o (sys_tick),
    .ext_tick_o (ext_tick)
  );

  // index 0 is the low half, index 1 the high half
  assign fast[0] = st_reg.lo_fast; // RL6
  assign fast[1] = st_reg.hi_fast; // RL6
  assign rld[0]  = st_reg.lo_rld;
  assign rld[1]  = st_reg.hi_rld;
  // 16-bit mode is not built: both halves hold while split is clear
  assign run[0]  = st_reg.split; // RL1 RL4
  assign run[1]  = st_reg.split & st_reg.run; // RL3
  assign cnt_wr[0] = bus_i.wr && bus_i.addr == `SDT_ADDR_LO_CNT; // RL14
  assign cnt_wr[1] = bus_i.wr && bus_i.addr == `SDT_ADDR_HI_CNT; // RL15

  for (genvar i = 0; i < 2; i++) begin : g_half
    assign tick[i] = fast[i] ? 1'b1 : (st_reg.ext_sel ? ext_tick : sys_tick); // RL5
    sdt_half_counter #(
      .WIDTH (8)
    ) u_half (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .tick_i    (tick[i]),
      .run_i     (run[i]),
      .reload_i  (rld[i]), // RL2
      .wr_i      (cnt_wr[i]),
      .wdata_i   (bus_i.wdata),
      .count_o   (cnt[i]),
      .ovf_o     (ovf[i])
    );
  end

  assign wr_ctl   = bus_i.wr && bus_i.addr == `SDT_ADDR_CTL;
  assign cmp_rise = cmp_out_i & ~st_reg.cmp_prev;

  always_comb begin
    evt_set                  = '0;
    evt_set[`SDT_EVT_HI_OVF] = ovf[1];
    evt_set[`SDT_EVT_LO_OVF] = ovf[0];
    evt_set[`SDT_EVT_CAPT]   = cmp_rise & st_reg.capt_en;
  end

  // register read mux; reserved bits read zero
  always_comb begin
    rd_mux = 8'h00;
    case (bus_i.addr)
      `SDT_ADDR_CTL: begin
        rd_mux[`SDT_CTL_HI_FLAG]   = st_reg.hi_flag; // RL16
        rd_mux[`SDT_CTL_LO_FLAG]   = st_reg.lo_flag; // RL16
        rd_mux[`SDT_CTL_LO_IRQ_EN] = st_reg.lo_irq_en;
        rd_mux[`SDT_CTL_CAPT_EN]   = st_reg.capt_en;
        rd_mux[`SDT_CTL_SPLIT]     = st_reg.split;
        rd_mux[`SDT_CTL_RUN]       = st_reg.run;
        rd_mux[`SDT_CTL_EXT_SEL]   = st_reg.ext_sel;
      end
      `SDT_ADDR_CLK_SEL: begin
        rd_mux[`SDT_CKS_HI_FAST] = st_reg.hi_fast;
        rd_mux[`SDT_CKS_LO_FAST] = st_reg.lo_fast;
      end
      `SDT_ADDR_IRQ_EN: begin
        rd_mux[`SDT_IRQ_EN_TIMER] = st_reg.tmr_irq_en;
      end
      `SDT_ADDR_LO_RLD:   rd_mux = st_reg.lo_rld;
      `SDT_ADDR_HI_RLD:   rd_mux = st_reg.hi_rld;
      `SDT_ADDR_LO_CNT:   rd_mux = cnt[0]; // RL14
      `SDT_ADDR_HI_CNT:   rd_mux = cnt[1]; // RL15
      `SDT_ADDR_LO_CAPT:  rd_mux = st_reg.lo_capt;
      `SDT_ADDR_HI_CAPT:  rd_mux = st_reg.hi_capt;
      `SDT_ADDR_EVT_STAT: rd_mux = {5'h00, st_reg.evt_stat};
      `SDT_ADDR_EVT_MASK: rd_mux = {5'h00, st_reg.evt_mask};
      default:            rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    st_next          = st_reg;
    st_next.cmp_prev = cmp_out_i;
    st_next.rdata    = bus_i.rd ? rd_mux : 8'h00;
    if (wr_ctl) begin
      st_next.lo_irq_en = bus_i.wdata[`SDT_CTL_LO_IRQ_EN];
      st_next.capt_en   = bus_i.wdata[`SDT_CTL_CAPT_EN];
      st_next.split     = bus_i.wdata[`SDT_CTL_SPLIT]; // RL1
      st_next.run       = bus_i.wdata[`SDT_CTL_RUN];
      st_next.ext_sel   = bus_i.wdata[`SDT_CTL_EXT_SEL];
    end
    // flags follow software writes, but a same-cycle overflow wins
    st_next.hi_flag = ovf[1] | (wr_ctl ? bus_i.wdata[`SDT_CTL_HI_FLAG] : st_reg.hi_flag); // RL7 RL11
    st_next.lo_flag = ovf[0] | (wr_ctl ? bus_i.wdata[`SDT_CTL_LO_FLAG] : st_reg.lo_flag); // RL8 RL11
    if (bus_i.wr) begin
      case (bus_i.addr)
        `SDT_ADDR_CLK_SEL: begin
          st_next.hi_fast = bus_i.wdata[`SDT_CKS_HI_FAST];
          st_next.lo_fast = bus_i.wdata[`SDT_CKS_LO_FAST];
        end
        `SDT_ADDR_IRQ_EN:   st_next.tmr_irq_en = bus_i.wdata[`SDT_IRQ_EN_TIMER];
        `SDT_ADDR_LO_RLD:   st_next.lo_rld   = bus_i.wdata;
        `SDT_ADDR_HI_RLD:   st_next.hi_rld   = bus_i.wdata;
        `SDT_ADDR_EVT_MASK: st_next.evt_mask = bus_i.wdata[2:0];
        default: ;
      endcase
    end
    // write one to clear; a new event in the same cycle stays set
    if (bus_i.wr && bus_i.addr == `SDT_ADDR_EVT_STAT) begin
      st_next.evt_stat = (st_reg.evt_stat & ~bus_i.wdata[2:0]) | evt_set;
    end else begin
      st_next.evt_stat = st_reg.evt_stat | evt_set;
    end
    if (evt_set[`SDT_EVT_CAPT]) begin
      st_next.lo_capt = cnt[0]; // RL13
      st_next.hi_capt = cnt[1]; // RL13
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg          <= '0;
      st_reg.lo_rld   <= `SDT_RST_BYTE;
      st_reg.hi_rld   <= `SDT_RST_BYTE;
      st_reg.evt_stat <= `SDT_RST_EVT;
      st_reg.evt_mask <= `SDT_RST_EVT;
    end else begin
      st_reg <= st_next;
    end
  end

  // high overflow requests when timer irq is enabled; low also needs its own enable
  assign tmr_req = st_reg.tmr_irq_en & (st_reg.hi_flag | (st_reg.lo_flag & st_reg.lo_irq_en)); // RL9 RL10
  assign irq_o   = tmr_req | (|(st_reg.evt_stat & st_reg.evt_mask));
  assign rdata_o = st_reg.rdata;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_hi_wrap;
    ovf[1] && !wr_ctl;
  endsequence

  sequence s_lo_wrap;
    ovf[0] && !wr_ctl;
  endsequence

  a_hi_flag_set: assert property (s_hi_wrap |=> st_reg.hi_flag && cnt[1] == $past(st_reg.hi_rld)) // RL7
    else $error("high wrap did not set flag and reload");

  a_lo_flag_set: assert property (s_lo_wrap |=> st_reg.lo_flag && cnt[0] == $past(st_reg.lo_rld)) // RL8
    else $error("low wrap did not set flag and reload");

  a_flag_no_clear: assert property (st_reg.hi_flag && !wr_ctl |=> st_reg.hi_flag) // RL11
    else $error("high overflow flag cleared by hardware");

  a_hi_run_gate: assert property (!st_reg.run && !cnt_wr[1] |=> $stable(cnt[1])) // RL3
    else $error("high counter moved while stopped");

  a_lo_free_run: assert property (st_reg.split && st_reg.lo_fast && !st_reg.run && !cnt_wr[0]
      && cnt[0] != 8'hFF |=> cnt[0] == $past(cnt[0]) + 8'h01) // RL4
    else $error("low counter not counting with run clear");

  a_irq_high: assert property (st_reg.tmr_irq_en && st_reg.hi_flag |-> irq_o) // RL9
    else $error("high overflow pending without interrupt");

  a_irq_low: assert property (st_reg.tmr_irq_en && st_reg.lo_irq_en && st_reg.lo_flag |-> irq_o) // RL10
    else $error("low overflow pending without interrupt");

  a_low_gated: assert property (!st_reg.tmr_irq_en && st_reg.evt_mask == 3'h0 |-> !irq_o) // RL10
    else $error("interrupt with everything disabled");

  a_capt_edge: assert property (st_reg.capt_en && $rose(cmp_out_i)
      |=> st_reg.lo_capt == $past(cnt[0]) && st_reg.hi_capt == $past(cnt[1])) // RL13
    else $error("comparator edge not captured");

  a_cnt_write: assert property (cnt_wr[0] |=> cnt[0] == $past(bus_i.wdata)) // RL14
    else $error("low count write lost");

  a_hi_write: assert property (cnt_wr[1] |=> cnt[1] == $past(bus_i.wdata)) // RL15
    else $error("high count write lost");

  a_read_once: assert property (bus_i.rd && bus_i.addr == `SDT_ADDR_LO_CNT && !cnt_wr[0]
      |=> rdata_o == $past(cnt[0])) // RL14
    else $error("low count read data wrong");

  a_ext_select: assert property (st_reg.split && !st_reg.lo_fast && st_reg.ext_sel && !ext_tick
      && !cnt_wr[0] |=> $stable(cnt[0])) // RL5 RL18
    else $error("low counter stepped without external tick");

  // a half sitting at the top with a step pending must wrap
  sequence s_lo_top;
    st_reg.split && tick[0] && cnt[0] == 8'hFF && !cnt_wr[0];
  endsequence

  sequence s_hi_top;
    st_reg.split && st_reg.run && tick[1] && cnt[1] == 8'hFF && !cnt_wr[1];
  endsequence

  a_lo_wrap_seen: assert property (s_lo_top |-> ovf[0]) // RL8
    else $error("low counter at top did not overflow");

  a_hi_wrap_seen: assert property (s_hi_top |-> ovf[1]) // RL7
    else $error("high counter at top did not overflow");

  a_lo_evt_set: assert property (s_lo_top |=> st_reg.evt_stat[`SDT_EVT_LO_OVF] && st_reg.lo_flag) // RL8
    else $error("low overflow event not recorded");

  a_hi_evt_set: assert property (s_hi_top |=> st_reg.evt_stat[`SDT_EVT_HI_OVF] && st_reg.hi_flag) // RL7
    else $error("high overflow event not recorded");

  a_lo_flag_hold: assert property (st_reg.lo_flag && !wr_ctl |=> st_reg.lo_flag) // RL11
    else $error("low overflow flag cleared by hardware");

  a_hi_sw_clear: assert property (wr_ctl && !ovf[1] && !bus_i.wdata[`SDT_CTL_HI_FLAG] // RL11
      |=> !st_reg.hi_flag)
    else $error("high overflow flag not cleared by software");

  a_lo_sw_clear: assert property (wr_ctl && !ovf[0] && !bus_i.wdata[`SDT_CTL_LO_FLAG] // RL11
      |=> !st_reg.lo_flag)
    else $error("low overflow flag not cleared by software");

  a_evt_set_wins: assert property ((|evt_set) |=> (st_reg.evt_stat & $past(evt_set)) == $past(evt_set)) // RL7 RL8
    else $error("event bit lost to a same-cycle clear");

  a_evt_w1c: assert property (bus_i.wr && bus_i.addr == `SDT_ADDR_EVT_STAT // RL13
      && bus_i.wdata[`SDT_EVT_CAPT] && !evt_set[`SDT_EVT_CAPT] |=> !st_reg.evt_stat[`SDT_EVT_CAPT])
    else $error("capture event not cleared by writing one");

  a_split_hold: assert property (!st_reg.split && !cnt_wr[0] && !cnt_wr[1] // RL1
      |=> $stable(cnt[0]) && $stable(cnt[1]))
    else $error("counter moved outside split mode");

  a_ctl_write: assert property (wr_ctl |=> st_reg.split == $past(bus_i.wdata[`SDT_CTL_SPLIT]) // RL1 RL3
      && st_reg.run == $past(bus_i.wdata[`SDT_CTL_RUN]))
    else $error("control write not applied");

  a_fast_write: assert property (bus_i.wr && bus_i.addr == `SDT_ADDR_CLK_SEL // RL6
      |=> st_reg.hi_fast == $past(bus_i.wdata[`SDT_CKS_HI_FAST])
      && st_reg.lo_fast == $past(bus_i.wdata[`SDT_CKS_LO_FAST]))
    else $error("clock select write not applied");

  a_hi_run_step: assert property (st_reg.split && st_reg.run && st_reg.hi_fast && !cnt_wr[1] // RL3 RL6
      && cnt[1] != 8'hFF |=> cnt[1] == $past(cnt[1]) + 8'h01)
    else $error("high counter not counting while run is set");

  a_lo_sys_gate: assert property (st_reg.split && !st_reg.lo_fast && !st_reg.ext_sel && !sys_tick // RL5
      && !cnt_wr[0] |=> $stable(cnt[0]))
    else $error("low counter stepped without divided system tick");

  a_lo_sys_step: assert property (st_reg.split && !st_reg.lo_fast && !st_reg.ext_sel && sys_tick // RL5
      && !cnt_wr[0] && cnt[0] != 8'hFF |=> cnt[0] == $past(cnt[0]) + 8'h01)
    else $error("low counter missed a divided system tick");

  a_lo_ext_step: assert property (st_reg.split && !st_reg.lo_fast && st_reg.ext_sel && ext_tick // RL18
      && !cnt_wr[0] && cnt[0] != 8'hFF |=> cnt[0] == $past(cnt[0]) + 8'h01)
    else $error("low counter missed an external tick");

  a_capt_evt: assert property (st_reg.capt_en && $rose(cmp_out_i) |=> st_reg.evt_stat[`SDT_EVT_CAPT]) // RL13
    else $error("capture event not recorded");

  a_capt_idle: assert property (!st_reg.capt_en |=> $stable(st_reg.lo_capt) && $stable(st_reg.hi_capt)) // RL13
    else $error("capture registers changed with capture off");

  a_irq_low_off: assert property (st_reg.tmr_irq_en && !st_reg.lo_irq_en && !st_reg.hi_flag // RL10
      && st_reg.evt_mask == 3'h0 |-> !irq_o)
    else $error("low overflow interrupted without its enable");

  a_rdata_idle: assert property (!bus_i.rd |=> rdata_o == 8'h00) // RL14
    else $error("read data stood longer than one cycle");

  a_hi_read: assert property (bus_i.rd && bus_i.addr == `SDT_ADDR_HI_CNT |=> rdata_o == $past(cnt[1])) // RL15
    else $error("high count read data wrong");

  a_flag_read: assert property (bus_i.rd && bus_i.addr == `SDT_ADDR_CTL // RL16
      |=> rdata_o[`SDT_CTL_HI_FLAG] == $past(st_reg.hi_flag)
      && rdata_o[`SDT_CTL_LO_FLAG] == $past(st_reg.lo_flag))
    else $error("overflow flags not at control bits 7 and 6");

endmodule : sdt_timer

/* File: tb_split_dual_8bit_reload_timer.sv */
`timescale 1ns/10ps
`include "sdt_map.svh"

module tb_split_dual_8bit_reload_timer;
  import sdt_pkg::*;

  logic         mclk_i       = 1'b0;
  logic         sys_rst_i    = 1'b1;
  logic         ext_clk_i    = 1'b0;
  logic         cmp_out_i    = 1'b0;
  sdt_bus_req_t bus_r        = '0;
  logic [7:0]   rdata_o;
  logic         irq_o;
  logic [7:0]   v;
  int           mismatches   = 0;
  int           total_checks = 0;

  always #2 mclk_i = ~mclk_i;

  sdt_timer dut_u (
    .mclk_i   (mclk_i),
    .sys_rst_i(sys_rst_i),
    .bus_i    (bus_r),
    .rdata_o  (rdata_o),
    .ext_clk_i(ext_clk_i),
    .cmp_out_i(cmp_out_i),
    .irq_o    (irq_o)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus_r.addr  <= a;
    bus_r.wdata <= d;
    bus_r.wr    <= 1'b1;
    @(posedge mclk_i);
    bus_r.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    bus_r.addr <= a;
    bus_r.rd   <= 1'b1;
    @(posedge mclk_i);
    bus_r.rd <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic irq_is(input logic exp);
    #1;
    check({7'h00, irq_o}, {7'h00, exp});
  endtask : irq_is

  // slow enough for the two-stage synchroniser to see every edge
  task automatic ext_edges(input int n);
    repeat (n) begin
      repeat (5) @(posedge mclk_i);
      ext_clk_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      ext_clk_i <= 1'b0;
    end
  endtask : ext_edges

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #80000;
    mismatches++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(`SDT_ADDR_LO_CNT, v);
    check(v, `SDT_RST_BYTE);
    rd(`SDT_ADDR_HI_CNT, v);
    check(v, `SDT_RST_BYTE);
    wr(8'h00, 8'h5A);
    rd(8'h00, v);
    check(v, 8'h00);
    // counters hold outside split mode, so readback is exact
    wr(`SDT_ADDR_LO_CNT, 8'hA5);
    wr(`SDT_ADDR_HI_CNT, 8'h5A);
    rd(`SDT_ADDR_LO_CNT, v);
    check(v, 8'hA5);
    rd(`SDT_ADDR_HI_CNT, v);
    check(v, 8'h5A);
    $display("test reset and access done");

    wr(`SDT_ADDR_CLK_SEL, 8'h30);
    wr(`SDT_ADDR_LO_RLD, 8'h40);
    wr(`SDT_ADDR_CTL, 8'h0A);
    wr(`SDT_ADDR_LO_CNT, 8'hFD);
    rd(`SDT_ADDR_LO_CNT, v);
    check(v, 8'hFE);
    rd(`SDT_ADDR_LO_CNT, v);
    check(v, 8'h40);
    rd(`SDT_ADDR_CTL, v);
    check(v, 8'h48);
    rd(`SDT_ADDR_HI_CNT, v);
    check(v, 8'h5A);
    $display("test low half done");

    wr(`SDT_ADDR_HI_RLD, 8'h80);
    wr(`SDT_ADDR_HI_CNT, 8'hFD);
    wr(`SDT_ADDR_CTL, 8'h0C);
    rd(`SDT_ADDR_HI_CNT, v);
    check(v, 8'hFE);
    rd(`SDT_ADDR_HI_CNT, v);
    check(v, 8'h80);
    rd(`SDT_ADDR_CTL, v);
    check(v & 8'h80, 8'h80);
    irq_is(1'b0);
    wr(`SDT_ADDR_IRQ_EN, 8'h20);
    irq_is(1'b1);
    wr(`SDT_ADDR_CTL, 8'h08);
    irq_is(1'b0);
    wr(`SDT_ADDR_CTL, 8'h28);
    for (int i = 0; i < 300 && irq_o !== 1'b1; i++) @(posedge mclk_i);
    irq_is(1'b1);
    rd(`SDT_ADDR_CTL, v);
    check(v, 8'h68);
    repeat (20) @(posedge mclk_i);
    rd(`SDT_ADDR_CTL, v);
    check(v, 8'h68);
    rd(`SDT_ADDR_EVT_STAT, v);
    check(v, 8'h03);
    wr(`SDT_ADDR_CTL, 8'h28);
    irq_is(1'b0);
    $display("test high half and interrupt done");

    wr(`SDT_ADDR_CLK_SEL, 8'h00);
    wr(`SDT_ADDR_CTL, 8'h09);
    wr(`SDT_ADDR_LO_CNT, 8'h00);
    ext_edges(40);
    repeat (10) @(posedge mclk_i);
    rd(`SDT_ADDR_LO_CNT, v);
    check(v, 8'h05);
    // divide-by-12 phase is free running, so one tick of slack
    wr(`SDT_ADDR_CLK_SEL, 8'h20);
    wr(`SDT_ADDR_CTL, 8'h0C);
    wr(`SDT_ADDR_LO_CNT, 8'h00);
    wr(`SDT_ADDR_HI_CNT, 8'h00);
    repeat (120) @(posedge mclk_i);
    rd(`SDT_ADDR_LO_CNT, v);
    check({7'h00, v == 8'h0A || v == 8'h0B}, 8'h01);
    rd(`SDT_ADDR_HI_CNT, v);
    check(v, 8'h7B);
    $display("test tick sources done");

    wr(`SDT_ADDR_IRQ_EN, 8'h00);
    wr(`SDT_ADDR_CLK_SEL, 8'h30);
    wr(`SDT_ADDR_CTL, 8'h1C);
    wr(`SDT_ADDR_EVT_MASK, 8'h04);
    wr(`SDT_ADDR_EVT_STAT, 8'h07);
    irq_is(1'b0);
    wr(`SDT_ADDR_HI_CNT, 8'h20);
    wr(`SDT_ADDR_LO_CNT, 8'h10);
    @(posedge mclk_i);
    cmp_out_i <= 1'b1;
    wr(`SDT_ADDR_LO_CAPT, 8'hFF);
    rd(`SDT_ADDR_LO_CAPT, v);
    check(v, 8'h11);
    rd(`SDT_ADDR_HI_CAPT, v);
    check(v, 8'h23);
    irq_is(1'b1);
    rd(`SDT_ADDR_EVT_STAT, v);
    check(v & 8'h04, 8'h04);
    wr(`SDT_ADDR_EVT_MASK, 8'h00);
    irq_is(1'b0);
    wr(`SDT_ADDR_EVT_MASK, 8'h04);
    irq_is(1'b1);
    wr(`SDT_ADDR_EVT_STAT, 8'h04);
    irq_is(1'b0);
    $display("test capture done");

    // reset in mid-run while both halves count
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(`SDT_ADDR_LO_CNT, v);
    check(v, `SDT_RST_BYTE);
    rd(`SDT_ADDR_HI_CNT, v);
    check(v, `SDT_RST_BYTE);
    irq_is(1'b0);
    $display("test mid-run reset done");
    end_of_test();
  end

endmodule : tb_split_dual_8bit_reload_timer
